// ### src/ext_ctrl_pkg.sv
// Behaviour
// - Inhibit active and honoured: no channel drives voltage, whatever enable and selects say.
// - Inhibit honoured only while config bit is 0; reset value 1 ignores it.
// - Setpoint writes are refused while output enable is on; value is kept.
// - Eight select inputs per group, four groups; only selected channels drive.
// - Busy rises at most 200 us after enable turns on.
// - Selected channels start driving at most 600 us after enable on.
// - Discharge action starts at most 1.2 ms after enable on.
// - Generated-voltage fault shows on the voltage alarm within 3.5 ms.
// - Busy falls at most 800 us after enable turns off.
// - Channel drive stops at most 2.5 ms after enable turns off.
// - Discharge action completes at most 1.1 ms after enable off.
// - Status outputs: voltage alarm, busy while outputting, over-temperature alarm.
package ext_ctrl_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CNT_W = 17;
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_CH = 8;
  localparam int SP_W = 16;
  localparam int SYNC_LAT = 7; // Pin edge to registered output, in cycles
  // Times in microseconds
  localparam int T_SETUP_US = 100;
  localparam int T_HOLD_US = 200;
  localparam int T_BUSY_ON_US = 200;
  localparam int T_DRIVE_ON_US = 600;
  localparam int T_DIS_ON_US = 1200;
  localparam int T_PULSE_US = 8000;
  localparam int T_BUSY_OFF_US = 800;
  localparam int T_DIS_END_US = 1100;
  localparam int T_OFF_US = 4000;
  // Least times round up, longest times round down
  localparam int C_SETUP = (T_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_HOLD = (T_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_BUSY_ON = T_BUSY_ON_US * 1000 / CLK_PERIOD_NS;
  localparam int C_DRIVE_ON = T_DRIVE_ON_US * 1000 / CLK_PERIOD_NS;
  localparam int C_DIS_ON = T_DIS_ON_US * 1000 / CLK_PERIOD_NS;
  localparam int C_PULSE = (T_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int C_BUSY_OFF = T_BUSY_OFF_US * 1000 / CLK_PERIOD_NS;
  localparam int C_DIS_END = T_DIS_END_US * 1000 / CLK_PERIOD_NS;
  localparam int C_OFF = (T_OFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;
  localparam int CFG_INHIBIT_BIT = 0;
  localparam logic CFG_INHIBIT_RST = 1'b1;
  localparam logic [SP_W-1:0] SETPOINT_RST = 16'h0000;
  // Event bits
  localparam int EV_SETUP = 0;
  localparam int EV_HOLD = 1;
  localparam int EV_PULSE = 2;
  localparam int EV_OFF = 3;
  localparam int EV_SP_REJ = 4;
  localparam int EV_VALARM = 5;
  localparam int EV_TEMP = 6;
  localparam int EV_INHIBIT = 7;
  localparam int NUM_EV = 8;
  // State register bits
  localparam int ST_ENABLE = 0;
  localparam int ST_INHIBIT = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_DISCH = 3;
  localparam int ST_VALARM = 4;
  localparam int ST_TEMP = 5;
  localparam int ST_DRIVING = 6;
  typedef enum logic [1:0] {st_idle, st_on, st_off} seq_state_type;
endpackage : ext_ctrl_pkg

// ### src/external_output_control_port.sv
`timescale 1ns/1ns
`default_nettype none
module external_output_control_port
  import ext_ctrl_pkg::*;
#(
  parameter logic [CNT_W-1:0] BUSY_ON_CYC = CNT_W'(C_BUSY_ON - SYNC_LAT),
  parameter logic [CNT_W-1:0] DRIVE_ON_CYC = CNT_W'(C_DRIVE_ON - SYNC_LAT),
  parameter logic [CNT_W-1:0] DIS_ON_CYC = CNT_W'(C_DIS_ON - SYNC_LAT),
  parameter logic [CNT_W-1:0] BUSY_OFF_CYC = CNT_W'(C_BUSY_OFF - SYNC_LAT),
  parameter logic [CNT_W-1:0] DIS_END_CYC = CNT_W'(C_DIS_END - SYNC_LAT),
  parameter logic [CNT_W-1:0] PULSE_CYC = CNT_W'(C_PULSE),
  parameter logic [CNT_W-1:0] OFF_CYC = CNT_W'(C_OFF)
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // External control inputs
  input wire logic output_enable,
  input wire logic [GROUP_CH-1:0] group_a_channel_select,
  input wire logic [GROUP_CH-1:0] group_b_channel_select,
  input wire logic [GROUP_CH-1:0] group_c_channel_select,
  input wire logic [GROUP_CH-1:0] group_d_channel_select,
  input wire logic safety_inhibit,
  // Analog monitors
  input wire logic voltage_fault,
  input wire logic over_temp,
  // Status outputs
  output logic busy,
  output logic voltage_alarm,
  output logic temp_alarm,
  // Power stage control
  output logic [NUM_GROUPS*GROUP_CH-1:0] channel_drive,
  output logic discharge_active,
  output logic [SP_W-1:0] setpoint,
  // Interrupt
  output logic irq
);

  localparam int IN_W = NUM_GROUPS * GROUP_CH + 4;
  localparam int SEL_W = NUM_GROUPS * GROUP_CH;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;
  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'(C_SETUP);
  localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(C_HOLD);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser and debounce

  logic [IN_W-1:0] raw_in;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic [IN_W-1:0] hist1;
  logic [IN_W-1:0] hist2;
  logic [IN_W-1:0] filt;
  logic [IN_W-1:0] next_filt;

  assign raw_in = {over_temp, voltage_fault, safety_inhibit, output_enable,
                   group_d_channel_select, group_c_channel_select,
                   group_b_channel_select, group_a_channel_select};

  // A bit follows only after three equal samples
  always_comb begin
    next_filt = (sync2 & hist1 & hist2) | (filt & (sync2 | hist1 | hist2));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      hist1 <= '0;
      hist2 <= '0;
      filt <= '0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      hist1 <= sync2;
      hist2 <= hist1;
      filt <= next_filt;
    end
  end

  logic [SEL_W-1:0] sel_f;
  logic oe_f;
  logic inh_f;
  logic vfault_f;
  logic temp_f;

  assign sel_f = filt[SEL_W-1:0];
  assign oe_f = filt[SEL_W];
  assign inh_f = filt[SEL_W+1];
  assign vfault_f = filt[SEL_W+2];
  assign temp_f = filt[SEL_W+3];

  //////////////////////////////////////////////////////////////////////////////
  // Output sequencer and host timing checks

  logic cfg_inhibit;
  logic inhibit_on;
  logic oe_rise;
  logic oe_fall;
  logic sel_change;

  seq_state_type state;
  seq_state_type next_state;
  logic [CNT_W-1:0] edge_cnt;
  logic [CNT_W-1:0] next_edge_cnt;
  logic [CNT_W-1:0] sel_cnt;
  logic [CNT_W-1:0] next_sel_cnt;
  logic oe_prev;
  logic [SEL_W-1:0] sel_prev;
  logic was_on;
  logic next_was_on;
  logic inh_prev;
  logic valarm_prev;
  logic temp_prev;
  logic next_busy;
  logic next_discharge;
  logic [SEL_W-1:0] next_drive;
  logic [NUM_EV-1:0] seq_ev;

  assign inhibit_on = inh_f & ~cfg_inhibit;
  assign oe_rise = oe_f & ~oe_prev;
  assign oe_fall = ~oe_f & oe_prev;
  assign sel_change = sel_f != sel_prev;

  always_comb begin
    next_state = state;
    next_was_on = was_on | oe_rise;
    next_edge_cnt = (edge_cnt == CNT_MAX) ? edge_cnt : edge_cnt + 1'b1;
    next_sel_cnt = (sel_cnt == CNT_MAX) ? sel_cnt : sel_cnt + 1'b1;
    seq_ev = '0;
    if (oe_rise || oe_fall) begin
      next_edge_cnt = '0;
    end
    if (sel_change) begin
      next_sel_cnt = '0;
    end
    if (oe_rise && sel_cnt < SETUP_CYC) begin
      seq_ev[EV_SETUP] = 1'b1;
    end
    if (sel_change && was_on && edge_cnt < HOLD_CYC) begin
      seq_ev[EV_HOLD] = 1'b1;
    end
    if (oe_fall && edge_cnt < PULSE_CYC) begin
      seq_ev[EV_PULSE] = 1'b1;
    end
    if (oe_rise && was_on && edge_cnt < OFF_CYC) begin
      seq_ev[EV_OFF] = 1'b1;
    end
    seq_ev[EV_VALARM] = vfault_f & ~valarm_prev;
    seq_ev[EV_TEMP] = temp_f & ~temp_prev;
    seq_ev[EV_INHIBIT] = inhibit_on & ~inh_prev;
    case (state)
      st_idle: begin
        if (oe_rise) begin
          next_state = st_on;
        end
      end
      st_on: begin
        if (oe_fall) begin
          next_state = st_off;
        end
      end
      st_off: begin
        if (oe_rise) begin
          next_state = st_on;
        end else if (edge_cnt >= DIS_END_CYC && edge_cnt >= BUSY_OFF_CYC) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    next_busy = 1'b0;
    next_discharge = 1'b0;
    next_drive = '0;
    if (state == st_on && !oe_fall) begin
      next_busy = edge_cnt >= BUSY_ON_CYC;
      next_discharge = edge_cnt >= DIS_ON_CYC;
      if (edge_cnt >= DRIVE_ON_CYC) begin
        next_drive = sel_f;
      end
    end else if ((state == st_off && !oe_rise) || (state == st_on && oe_fall)) begin
      next_busy = busy && (state == st_on || edge_cnt < BUSY_OFF_CYC);
      next_discharge = discharge_active && (state == st_on || edge_cnt < DIS_END_CYC);
    end
    if (inhibit_on) begin
      next_busy = 1'b0;
      next_drive = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      edge_cnt <= '0;
      sel_cnt <= '0;
      oe_prev <= 1'b0;
      sel_prev <= '0;
      was_on <= 1'b0;
      inh_prev <= 1'b0;
      valarm_prev <= 1'b0;
      temp_prev <= 1'b0;
      busy <= 1'b0;
      discharge_active <= 1'b0;
      channel_drive <= '0;
      voltage_alarm <= 1'b0;
      temp_alarm <= 1'b0;
    end else begin
      state <= next_state;
      edge_cnt <= next_edge_cnt;
      sel_cnt <= next_sel_cnt;
      oe_prev <= oe_f;
      sel_prev <= sel_f;
      was_on <= next_was_on;
      inh_prev <= inhibit_on;
      valarm_prev <= vfault_f;
      temp_prev <= temp_f;
      busy <= next_busy;
      discharge_active <= next_discharge;
      channel_drive <= next_drive;
      voltage_alarm <= vfault_f;
      temp_alarm <= temp_f;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite register file and interrupts

  logic dp_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic next_dp_valid;
  logic next_dp_write;
  logic [7:0] next_dp_addr;
  logic next_cfg_inhibit;
  logic [SP_W-1:0] next_setpoint;
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] next_int_status;
  logic [NUM_EV-1:0] int_enable;
  logic [NUM_EV-1:0] next_int_enable;
  logic [NUM_EV-1:0] int_clear;
  logic [NUM_EV-1:0] all_ev;
  logic [31:0] next_hrdata;
  logic [31:0] state_word;

  always_comb begin
    state_word = '0;
    state_word[ST_ENABLE] = oe_f;
    state_word[ST_INHIBIT] = inhibit_on;
    state_word[ST_BUSY] = busy;
    state_word[ST_DISCH] = discharge_active;
    state_word[ST_VALARM] = voltage_alarm;
    state_word[ST_TEMP] = temp_alarm;
    state_word[ST_DRIVING] = |channel_drive;
  end

  always_comb begin
    next_dp_valid = hsel & htrans[1] & hready & (hsize == 3'h2);
    next_dp_write = hwrite;
    next_dp_addr = haddr[7:0];
    next_cfg_inhibit = cfg_inhibit;
    next_setpoint = setpoint;
    next_int_enable = int_enable;
    int_clear = '0;
    all_ev = seq_ev;
    if (dp_valid && dp_write) begin
      case (dp_addr)
        OFS_CONFIG: begin
          next_cfg_inhibit = hwdata[CFG_INHIBIT_BIT];
        end
        OFS_SETPOINT: begin
          if (oe_f) begin
            all_ev[EV_SP_REJ] = 1'b1;
          end else begin
            next_setpoint = hwdata[SP_W-1:0];
          end
        end
        OFS_INT_ENABLE: begin
          next_int_enable = hwdata[NUM_EV-1:0];
        end
        OFS_INT_CLEAR: begin
          int_clear = hwdata[NUM_EV-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event outweighs a clear in the same cycle
    next_int_status = (int_status & ~int_clear) | all_ev;
    next_hrdata = '0;
    if (next_dp_valid && !hwrite) begin
      case (haddr[7:0])
        OFS_CONFIG: next_hrdata[CFG_INHIBIT_BIT] = cfg_inhibit;
        OFS_SETPOINT: next_hrdata[SP_W-1:0] = setpoint;
        OFS_STATE: next_hrdata = state_word;
        OFS_INT_STATUS: next_hrdata[NUM_EV-1:0] = int_status;
        OFS_INT_ENABLE: next_hrdata[NUM_EV-1:0] = int_enable;
        default: next_hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= '0;
      cfg_inhibit <= CFG_INHIBIT_RST;
      setpoint <= SETPOINT_RST;
      int_status <= '0;
      int_enable <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
    end else begin
      dp_valid <= next_dp_valid;
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      cfg_inhibit <= next_cfg_inhibit;
      setpoint <= next_setpoint;
      int_status <= next_int_status;
      int_enable <= next_int_enable;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= |(next_int_status & next_int_enable);
    end
  end

endmodule : external_output_control_port
`default_nettype wire

// ### test/port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module port_monitor
  import ext_ctrl_pkg::*;
#(
  parameter logic [CNT_W-1:0] BUSY_ON_CYC = 17'h14,
  parameter logic [CNT_W-1:0] DIS_ON_CYC = 17'h3c,
  parameter logic [CNT_W-1:0] DRIVE_ON_CYC = 17'h28,
  parameter logic [CNT_W-1:0] BUSY_OFF_CYC = 17'h1e,
  parameter logic [CNT_W-1:0] DIS_END_CYC = 17'h1e
)(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Control lines
  input wire logic output_enable,
  input wire logic [GROUP_CH-1:0] group_a_channel_select,
  input wire logic [GROUP_CH-1:0] group_b_channel_select,
  input wire logic [GROUP_CH-1:0] group_c_channel_select,
  input wire logic [GROUP_CH-1:0] group_d_channel_select,
  input wire logic safety_inhibit,
  input wire logic voltage_fault,
  input wire logic over_temp,
  // Outputs watched
  input wire logic busy,
  input wire logic voltage_alarm,
  input wire logic temp_alarm,
  input wire logic [NUM_GROUPS*GROUP_CH-1:0] channel_drive,
  input wire logic discharge_active,
  input wire logic [SP_W-1:0] setpoint
);
  localparam int L_BON = int'(BUSY_ON_CYC) + 8;
  localparam int L_DRV = int'(DRIVE_ON_CYC) + 8;
  localparam int L_DON = int'(DIS_ON_CYC) + 8;
  localparam int L_BOFF = int'(BUSY_OFF_CYC) + 8;
  localparam int L_DEND = int'(DIS_END_CYC) + 8;
  logic cfg_wr;
  logic cfg_zero;
  int on_run;
  int off_run;
  logic inh_held;
  assign inh_held = cfg_zero && safety_inhibit;
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the inhibit configuration bit, and run lengths of the enable level
  // Timing is only owed after an on pulse or off pause long enough to reach the limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_wr <= 1'b0;
      cfg_zero <= 1'b0;
      on_run <= 0;
      off_run <= 0;
    end else begin
      cfg_wr <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2 && haddr[7:0] == OFS_CONFIG;
      if (cfg_wr) cfg_zero <= !hwdata[0];
      on_run <= output_enable ? on_run + 1 : 0;
      off_run <= output_enable ? 0 : off_run + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  busy_on_a: assert property (on_run == L_BON && !inh_held |-> busy)
    else $error("busy late after enable");
  drive_on_a: assert property (on_run == L_DRV && !inh_held |->
    channel_drive == {group_d_channel_select, group_c_channel_select, group_b_channel_select,
    group_a_channel_select}) else $error("drive late or wrong");
  dis_on_a: assert property (on_run == L_DON && !inh_held |-> discharge_active)
    else $error("discharge late");
  busy_off_a: assert property (off_run == L_BOFF |-> !busy)
    else $error("busy held after enable off");
  drive_off_a: assert property (off_run == 8 |-> channel_drive == 32'h0)
    else $error("drive held after enable off");
  dis_end_a: assert property (off_run == L_DEND |-> !discharge_active)
    else $error("discharge not ended");
  inhibit_cut_a: assert property ((cfg_zero && safety_inhibit) [*8] |-> channel_drive == 32'h0 && !busy)
    else $error("output while inhibited");
  valarm_copy_a: assert property (voltage_fault [*8] |-> voltage_alarm)
    else $error("voltage alarm missing");
  temp_copy_a: assert property (over_temp [*8] |=> temp_alarm)
    else $error("temperature alarm missing");
  setpoint_hold_a: assert property (output_enable [*8] |-> $stable(setpoint))
    else $error("setpoint changed while enabled");
  cover property ($rose(busy));
  cover property (cfg_zero && safety_inhibit && output_enable);
  cover property ($fell(discharge_active));
endmodule : port_monitor
bind external_output_control_port port_monitor #(.BUSY_ON_CYC(BUSY_ON_CYC), .DIS_ON_CYC(DIS_ON_CYC),
  .DRIVE_ON_CYC(DRIVE_ON_CYC), .BUSY_OFF_CYC(BUSY_OFF_CYC), .DIS_END_CYC(DIS_END_CYC)) port_monitor_inst (.*);
`default_nettype wire

// ### test/ext_controller.sv
`timescale 1ns/1ns
`default_nettype none
module ext_controller
  import ext_ctrl_pkg::*;
#(
  parameter int MIN_ON = 210,
  parameter int MIN_OFF = 110
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench; rude drops all timing care
  input wire logic req_on,
  input wire logic rude,
  input wire logic [31:0] req_sel,
  // Level lines to the port
  output logic output_enable,
  output logic [31:0] sel
);
  int cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      output_enable <= 1'b0;
      sel <= 32'h0;
      cnt <= 0;
    end else if (rude) begin
      output_enable <= req_on;
      sel <= req_sel;
    end else begin
      cnt <= cnt + 1;
      if (!output_enable && sel != req_sel && cnt >= C_HOLD + 10) begin
        sel <= req_sel;
        cnt <= 0;
      end else if (!output_enable && req_on && sel == req_sel && cnt >= C_SETUP + 10 && cnt >= MIN_OFF) begin
        output_enable <= 1'b1;
        cnt <= 0;
      end else if (output_enable && !req_on && cnt >= MIN_ON) begin
        output_enable <= 1'b0;
        cnt <= 0;
      end
    end
  end
endmodule : ext_controller
`default_nettype wire

// ### test/external_output_control_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module external_output_control_port_tb_top
  import ext_ctrl_pkg::*;
;
  localparam logic [CNT_W-1:0] BON = 17'h14;
  localparam logic [CNT_W-1:0] DON = 17'h3c;
  localparam logic [CNT_W-1:0] BOFF = 17'h1e;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, req_on = 1'b0, rude = 1'b0;
  logic safety_inhibit = 1'b0, voltage_fault = 1'b0, over_temp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, req_sel = 32'h0, rd;
  wire logic hready, hreadyout, hresp, output_enable, busy, voltage_alarm, temp_alarm, discharge_active, irq;
  wire logic [31:0] hrdata, channel_drive, sel_bus;
  wire logic [15:0] setpoint;
  int mismatches = 0, check_count = 0, cyc = 0;
  assign hready = hreadyout;
  always #50 clk = ~clk;
  ext_controller ext_controller_inst (.clk, .rst, .req_on, .rude, .req_sel, .output_enable, .sel(sel_bus));
  external_output_control_port #(.BUSY_ON_CYC(BON), .DRIVE_ON_CYC(17'h28), .DIS_ON_CYC(DON),
    .BUSY_OFF_CYC(BOFF), .DIS_END_CYC(BOFF), .PULSE_CYC(17'hc8), .OFF_CYC(17'h64)
  ) external_output_control_port_inst (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .output_enable, .group_a_channel_select(sel_bus[7:0]),
    .group_b_channel_select(sel_bus[15:8]), .group_c_channel_select(sel_bus[23:16]),
    .group_d_channel_select(sel_bus[31:24]), .safety_inhibit, .voltage_fault, .over_temp, .busy,
    .voltage_alarm, .temp_alarm, .channel_drive, .discharge_active, .setpoint, .irq);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single AHB transfer; waits for hready in each phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic pick(input int k);
    case (k)
      0: return output_enable;
      1: return busy;
      default: return discharge_active;
    endcase
  endfunction : pick
  task automatic wait_for(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, pick(k)}, {31'h0, v});
  endtask : wait_for
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      $display("ERROR at %0t: timeout", $time);
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFS_CONFIG, 32'h0); chk(rd, 32'h1);
    bus(1'b0, OFS_SETPOINT, 32'h0); chk(rd, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    bus(1'b0, 8'h40, 32'h0); chk(rd, 32'h0);
    bus(1'b1, OFS_SETPOINT, 32'h1234);
    bus(1'b1, OFS_INT_ENABLE, 32'hff);
    $display("test registers done");
    req_sel <= 32'h8142a5c3;
    req_on <= 1'b1;
    wait_for(0, 1'b1, 4000);
    wait_for(1, 1'b1, BON + 8);
    wait_for(2, 1'b1, DON + 8);
    chk(channel_drive, 32'h8142a5c3);
    bus(1'b1, OFS_SETPOINT, 32'h5555);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b0, OFS_SETPOINT, 32'h0); chk(rd, 32'h1234);
    chk({16'h0, setpoint}, 32'h1234);
    bus(1'b0, OFS_INT_STATUS, 32'h0); chk(rd, 32'h10);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_INT_CLEAR, 32'hff);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    req_on <= 1'b0;
    wait_for(0, 1'b0, 400);
    repeat (10) begin
      @(posedge clk);
      chk({31'h0, busy}, 32'h1);
    end
    wait_for(1, 1'b0, BOFF + 8);
    chk(channel_drive, 32'h0);
    wait_for(2, 1'b0, BOFF + 8);
    $display("test pulse done");
    safety_inhibit <= 1'b1;
    req_on <= 1'b1;
    wait_for(0, 1'b1, 4000);
    wait_for(1, 1'b1, BON + 8);
    req_on <= 1'b0;
    wait_for(0, 1'b0, 400);
    wait_for(1, 1'b0, BOFF + 8);
    bus(1'b1, OFS_CONFIG, 32'h0);
    req_on <= 1'b1;
    wait_for(0, 1'b1, 4000);
    repeat (DON + 16) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
    chk(channel_drive, 32'h0);
    bus(1'b0, OFS_INT_STATUS, 32'h0); chk(rd & 32'h80, 32'h80);
    req_on <= 1'b0;
    safety_inhibit <= 1'b0;
    wait_for(0, 1'b0, 400);
    $display("test inhibit done");
    bus(1'b1, OFS_INT_CLEAR, 32'hff);
    rude <= 1'b1;
    req_sel <= 32'h000000ff;
    req_on <= 1'b1;
    repeat (10) @(posedge clk);
    req_sel <= 32'h0000ff00;
    repeat (10) @(posedge clk);
    req_on <= 1'b0;
    repeat (20) @(posedge clk);
    req_on <= 1'b1;
    repeat (20) @(posedge clk);
    req_on <= 1'b0;
    repeat (10) @(posedge clk);
    bus(1'b0, OFS_INT_STATUS, 32'h0); chk(rd & 32'h0f, 32'h0f);
    bus(1'b1, OFS_INT_ENABLE, 32'h40);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    $display("test timing events done");
    voltage_fault <= 1'b1;
    repeat (2) @(posedge clk);
    voltage_fault <= 1'b0;
    repeat (8) begin
      @(posedge clk);
      chk({31'h0, voltage_alarm}, 32'h0);
    end
    voltage_fault <= 1'b1;
    over_temp <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, voltage_alarm, temp_alarm}, 32'h3);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, OFS_INT_STATUS, 32'h0); chk(rd & 32'h60, 32'h60);
    voltage_fault <= 1'b0;
    over_temp <= 1'b0;
    repeat (8) @(posedge clk);
    chk({30'h0, voltage_alarm, temp_alarm}, 32'h0);
    $display("test alarms done");
    final_report();
  end
endmodule : external_output_control_port_tb_top
`default_nettype wire
